// File: core/temp_result_limit_logic.sv
/*
  Temperature result formatting, readback, freeze, averaging,
  conversion timing, limit compare and overtemperature fan forcing.
  Assumes a decoded register access port from the serial bus
  slave and converter samples from logic on the same clock.
*/
`timescale 1ns/1ps
`include "temp_result_regs.svh"

module temp_result_limit_logic
  import temp_result_pkg::*;
#(
  parameter int VOLT_FAST  = `VOLT_FAST_US * `CLK_MHZ,
  parameter int REM_FAST   = `REM_FAST_US * `CLK_MHZ,
  parameter int LOCAL_FAST = `LOCAL_FAST_US * `CLK_MHZ,
  parameter int VOLT_AVG   = `VOLT_AVG_US * `CLK_MHZ,
  parameter int REM_AVG    = `REM_AVG_US * `CLK_MHZ,
  parameter int LOCAL_AVG  = `LOCAL_AVG_US * `CLK_MHZ
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Decoded register access.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Converter samples.
  input  wire logic [9:0] adc_temp,
  input  wire logic [7:0] adc_volt,
  input  wire logic [1:0] diode_fault,
  output chan_type        conv_channel,
  // Fan tach and fan loop.
  input  wire logic [15:0] fan1_period,
  input  wire logic        fan1_period_valid,
  input  wire logic        auto_fan_mode,
  // Results.
  output status_type      status,
  output duty_type        force_duty,
  output logic            force_active
);

  // Maps a code onto an unsigned ordering key.
  function automatic logic [7:0] key(input logic [7:0] v,
                                     input logic c);
    key = c ? {~v[7], v[6:0]} : v;
  endfunction

  // Applies the compat floor to a written limit.
  function automatic logic [7:0] lim(input logic [7:0] l,
                                     input logic c);
    lim = (c && $signed(l) < $signed(`CODE_MIN_CMP))
          ? `CODE_MIN_CMP : l;
  endfunction

  // Round-robin successor of a channel.
  function automatic chan_type next_ch(input chan_type c);
    case (c)
      CH_CORE:  next_ch = CH_MAIN;
      CH_MAIN:  next_ch = CH_LOCAL;
      CH_LOCAL: next_ch = CH_REM1;
      CH_REM1:  next_ch = CH_REM2;
      default:  next_ch = CH_CORE;
    endcase
  endfunction

  // Writable configuration and limit registers.
  logic [7:0] maxduty1, maxduty2, maxduty3;
  logic [7:0] core_lo, core_hi, main_lo, main_hi;
  logic [7:0] rem1_lo, rem1_hi, local_lo, local_hi;
  logic [7:0] rem2_lo, rem2_hi;
  logic [7:0] fan1_lo, fan1_hi;
  logic [7:0] rem1_ot, local_ot, rem2_ot;
  logic [7:0] hyst_a, hyst_b;
  logic [7:0] conv_cfg, boost_cfg, ot_timer;
  logic [7:0] format_cfg, duty_cfg;

  // Stored readings.
  logic [7:0] rem1_val, local_val, rem2_val;
  logic [1:0] remote1_frac_bits, local_frac_bits;
  logic [1:0] remote2_frac_bits;

  // Freeze state and the value reads seen since it began.
  logic       frozen;
  logic [2:0] seen;

  // Conversion sequencer.
  logic [18:0] sub_cnt;
  logic [3:0]  sub_idx;
  logic [13:0] acc;
  logic [2:0]  ot_state;

  // Configuration decode.
  wire compat    = format_cfg[`BIT_COMPAT];
  wire avg_on    = ~conv_cfg[`BIT_AVG_OFF];
  wire single    = conv_cfg[`BIT_SINGLE];
  wire boost     = boost_cfg[`BIT_BOOST];
  wire use_max   = duty_cfg[`BIT_USE_MAXDUTY];
  wire [2:0] sel = fan1_hi[7:5];
  wire wr_hit    = reg_wr;

  wire sel_ok = (sel == CH_REM1) || (sel == CH_LOCAL) ||
                (sel == CH_REM2);

  wire is_temp = conv_channel[2];
  wire is_rem  = (conv_channel == CH_REM1) ||
                 (conv_channel == CH_REM2);
  wire [18:0] full_len =
    is_rem ? (avg_on ? 19'(REM_AVG) : 19'(REM_FAST)) :
    is_temp ? (avg_on ? 19'(LOCAL_AVG) : 19'(LOCAL_FAST)) :
    (avg_on ? 19'(VOLT_AVG) : 19'(VOLT_FAST));
  wire [18:0] sub_len = avg_on ? (full_len >> `AVG_SHIFT)
                               : full_len;
  wire sub_end  = (sub_cnt + 19'd1 >= sub_len);
  wire last_sub = ~avg_on || (sub_idx == 4'hF);
  wire conv_end = sub_end && last_sub;

  // Sample to accumulate this cycle.
  wire [9:0]  sample = is_temp ? adc_temp : {adc_volt, 2'b00};
  wire [13:0] acc_sum = acc + {4'h0, sample};
  wire [9:0]  code10 = avg_on ? acc_sum[13:4] : acc_sum[9:0];

  wire [7:0] ext_int = code10[9:2];
  wire fault = (conv_channel == CH_REM1) ? diode_fault[0] :
               (conv_channel == CH_REM2) ? diode_fault[1] : 1'b0;

  wire under = (ext_int == 8'h00);
  wire over  = (ext_int > `EXT_TOP);
  wire [7:0] cmp_int = under ? `CODE_MIN_CMP :
                       over  ? `CODE_MAX_CMP :
                       8'(ext_int - `EXT_OFFSET);

  wire [7:0] new_val =
    fault ? (compat ? `CODE_FAULT_CMP : `CODE_FAULT_EXT) :
    (compat ? cmp_int : ext_int);
  wire [1:0] new_frac =
    (fault || (compat && (under || over))) ? 2'b00 : code10[1:0];

  // Limits and overtemp figures of the active channel.
  wire [7:0] ch_lo = (conv_channel == CH_REM1)  ? rem1_lo :
                     (conv_channel == CH_LOCAL) ? local_lo :
                     rem2_lo;
  wire [7:0] ch_hi = (conv_channel == CH_REM1)  ? rem1_hi :
                     (conv_channel == CH_LOCAL) ? local_hi :
                     rem2_hi;
  wire [7:0] ch_ot = (conv_channel == CH_REM1)  ? rem1_ot :
                     (conv_channel == CH_LOCAL) ? local_ot :
                     rem2_ot;
  wire [3:0] ch_hy = (conv_channel == CH_REM1)  ? hyst_a[7:4] :
                     (conv_channel == CH_LOCAL) ? hyst_a[3:0] :
                     hyst_b[7:4];
  wire [1:0] ot_idx = (conv_channel == CH_REM1)  ? 2'd0 :
                      (conv_channel == CH_LOCAL) ? 2'd1 : 2'd2;

  wire [7:0] k_val = key(new_val, compat);
  wire t_out = (k_val > key(lim(ch_hi, compat), compat)) ||
               (k_val <= key(lim(ch_lo, compat), compat));

  // Voltage window compare on raw codes.
  wire [7:0] v_val = code10[9:2];
  wire v_core = (v_val > core_hi) || (v_val <= core_lo);
  wire v_main = (v_val > main_hi) || (v_val <= main_lo);

  wire [7:0] k_ot  = key(lim(ch_ot, compat), compat);
  wire hot = k_val > k_ot;
  wire [7:0] k_rel = (k_ot > {4'h0, ch_hy}) ?
                     8'(k_ot - {4'h0, ch_hy}) : 8'h00;
  wire cool = boost ? ~hot : (k_val < k_rel);

  wire store_t = conv_end && is_temp && ~frozen;

  wire chan_type nxt = (single && sel_ok) ? chan_type'(sel)
                                          : next_ch(conv_channel);

  // Sub-period counter, sample index and accumulator.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sub_cnt <= 19'd0;
      sub_idx <= 4'h0;
      acc     <= 14'h0;
    end else if (sub_end) begin
      sub_cnt <= 19'd0;
      sub_idx <= last_sub ? 4'h0 : sub_idx + 4'h1;
      acc     <= last_sub ? 14'h0 : acc_sum;
    end else begin
      sub_cnt <= sub_cnt + 19'd1;
    end
  end

  // Channel pointer moves at each conversion end.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_channel <= CH_CORE;
    end else if (conv_end) begin
      conv_channel <= nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rem1_val          <= `RST_ZERO;
      local_val         <= `RST_ZERO;
      rem2_val          <= `RST_ZERO;
      remote1_frac_bits <= 2'b00;
      local_frac_bits   <= 2'b00;
      remote2_frac_bits <= 2'b00;
    end else if (store_t) begin
      case (conv_channel)
        CH_REM1: begin
          rem1_val          <= new_val;
          remote1_frac_bits <= new_frac;
        end
        CH_LOCAL: begin
          local_val       <= new_val;
          local_frac_bits <= new_frac;
        end
        default: begin
          rem2_val          <= new_val;
          remote2_frac_bits <= new_frac;
        end
      endcase
    end
  end

  // Read strobes of the freeze protocol.
  wire rd_frac = reg_rd && (reg_addr == `OFS_FRAC);
  wire [2:0] rd_val = {reg_rd && (reg_addr == `OFS_REM2_VAL),
                       reg_rd && (reg_addr == `OFS_LOCAL_VAL),
                       reg_rd && (reg_addr == `OFS_REM1_VAL)};
  wire [2:0] seen_nx = seen | rd_val;

  // Freeze begins on a fraction read, ends once all three values are read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frozen <= 1'b0;
      seen   <= 3'b000;
    end else if (rd_frac) begin
      frozen <= 1'b1;
      seen   <= 3'b000;
    end else if (frozen) begin
      seen   <= (&seen_nx) ? 3'b000 : seen_nx;
      frozen <= ~(&seen_nx);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= '0;
    end else begin
      if (conv_end) begin
        case (conv_channel)
          CH_CORE:  status.core    <= v_core;
          CH_MAIN:  status.main    <= v_main;
          CH_REM1:  status.rem1    <= t_out;
          CH_LOCAL: status.local_t <= t_out;
          default:  status.rem2    <= t_out;
        endcase
      end
      if (fan1_period_valid) begin
        status.fan1 <= fan1_period > {fan1_hi, fan1_lo};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ot_state <= 3'b000;
    end else if (conv_end && is_temp) begin
      if (hot) begin
        ot_state[ot_idx] <= 1'b1;
      end else if (cool) begin
        ot_state[ot_idx] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      force_active <= 1'b0;
      force_duty   <= '0;
    end else begin
      force_active   <= auto_fan_mode && (|ot_state);
      force_duty.ch1 <= use_max ? maxduty1 : `DUTY_FULL;
      force_duty.ch2 <= use_max ? maxduty2 : `DUTY_FULL;
      force_duty.ch3 <= use_max ? maxduty3 : `DUTY_FULL;
    end
  end

  // Register writes; read-only offsets ignore writes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      maxduty1   <= `RST_FF;
      maxduty2   <= `RST_FF;
      maxduty3   <= `RST_FF;
      core_lo    <= `RST_ZERO;
      core_hi    <= `RST_FF;
      main_lo    <= `RST_ZERO;
      main_hi    <= `RST_FF;
      rem1_lo    <= `RST_TEMP_LO;
      rem1_hi    <= `RST_TEMP_HI;
      local_lo   <= `RST_TEMP_LO;
      local_hi   <= `RST_TEMP_HI;
      rem2_lo    <= `RST_TEMP_LO;
      rem2_hi    <= `RST_TEMP_HI;
      fan1_lo    <= `RST_FF;
      fan1_hi    <= `RST_FF;
      rem1_ot    <= `RST_OT_LIM;
      local_ot   <= `RST_OT_LIM;
      rem2_ot    <= `RST_OT_LIM;
      hyst_a     <= `RST_HYST_A;
      hyst_b     <= `RST_HYST_B;
      conv_cfg   <= `RST_ZERO;
      boost_cfg  <= `RST_ZERO;
      ot_timer   <= `RST_ZERO;
      format_cfg <= `RST_ZERO;
      duty_cfg   <= `RST_ZERO;
    end else if (wr_hit) begin
      case (reg_addr)
        `OFS_MAXDUTY1:   maxduty1   <= reg_wdata;
        `OFS_MAXDUTY2:   maxduty2   <= reg_wdata;
        `OFS_MAXDUTY3:   maxduty3   <= reg_wdata;
        `OFS_CORE_LO:    core_lo    <= reg_wdata;
        `OFS_CORE_HI:    core_hi    <= reg_wdata;
        `OFS_MAIN_LO:    main_lo    <= reg_wdata;
        `OFS_MAIN_HI:    main_hi    <= reg_wdata;
        `OFS_REM1_LO:    rem1_lo    <= reg_wdata;
        `OFS_REM1_HI:    rem1_hi    <= reg_wdata;
        `OFS_LOCAL_LO:   local_lo   <= reg_wdata;
        `OFS_LOCAL_HI:   local_hi   <= reg_wdata;
        `OFS_REM2_LO:    rem2_lo    <= reg_wdata;
        `OFS_REM2_HI:    rem2_hi    <= reg_wdata;
        `OFS_FAN1_LO:    fan1_lo    <= reg_wdata;
        `OFS_FAN1_HI:    fan1_hi    <= reg_wdata;
        `OFS_REM1_OT:    rem1_ot    <= reg_wdata;
        `OFS_LOCAL_OT:   local_ot   <= reg_wdata;
        `OFS_REM2_OT:    rem2_ot    <= reg_wdata;
        `OFS_HYST_A:     hyst_a     <= reg_wdata;
        `OFS_HYST_B:     hyst_b     <= reg_wdata;
        `OFS_CONV_CFG:   conv_cfg   <= reg_wdata;
        `OFS_BOOST_CFG:  boost_cfg  <= reg_wdata;
        `OFS_OT_TIMER:   ot_timer   <= reg_wdata;
        `OFS_FORMAT_CFG: format_cfg <= reg_wdata;
        `OFS_DUTY_CFG:   duty_cfg   <= reg_wdata;
        default: ;
      endcase
    end
  end

  wire [7:0] frac_word = {remote2_frac_bits, local_frac_bits,
                          remote1_frac_bits, 2'b00};

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `OFS_REM1_VAL:   rd_mux = rem1_val;
      `OFS_LOCAL_VAL:  rd_mux = local_val;
      `OFS_REM2_VAL:   rd_mux = rem2_val;
      `OFS_FRAC:       rd_mux = frac_word;
      `OFS_MAXDUTY1:   rd_mux = maxduty1;
      `OFS_MAXDUTY2:   rd_mux = maxduty2;
      `OFS_MAXDUTY3:   rd_mux = maxduty3;
      `OFS_CORE_LO:    rd_mux = core_lo;
      `OFS_CORE_HI:    rd_mux = core_hi;
      `OFS_MAIN_LO:    rd_mux = main_lo;
      `OFS_MAIN_HI:    rd_mux = main_hi;
      `OFS_REM1_LO:    rd_mux = rem1_lo;
      `OFS_REM1_HI:    rd_mux = rem1_hi;
      `OFS_LOCAL_LO:   rd_mux = local_lo;
      `OFS_LOCAL_HI:   rd_mux = local_hi;
      `OFS_REM2_LO:    rd_mux = rem2_lo;
      `OFS_REM2_HI:    rd_mux = rem2_hi;
      `OFS_FAN1_LO:    rd_mux = fan1_lo;
      `OFS_FAN1_HI:    rd_mux = fan1_hi;
      `OFS_REM1_OT:    rd_mux = rem1_ot;
      `OFS_LOCAL_OT:   rd_mux = local_ot;
      `OFS_REM2_OT:    rd_mux = rem2_ot;
      `OFS_HYST_A:     rd_mux = hyst_a;
      `OFS_HYST_B:     rd_mux = hyst_b;
      `OFS_CONV_CFG:   rd_mux = conv_cfg;
      `OFS_BOOST_CFG:  rd_mux = boost_cfg;
      `OFS_OT_TIMER:   rd_mux = ot_timer;
      `OFS_FORMAT_CFG: rd_mux = format_cfg;
      `OFS_DUTY_CFG:   rd_mux = duty_cfg;
      default:         rd_mux = 8'h00;
    endcase
  end

  // Read data is registered on the read strobe.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule

// File: core/temp_result_regs.svh
/*
  Register offsets, field positions, reset values and timing
  figures of the temperature result and limit logic.
  Assumes nothing of its surroundings; definitions only.
*/
`ifndef TEMP_RESULT_REGS_SVH
`define TEMP_RESULT_REGS_SVH

// Register offsets on the serial management bus.
`define OFS_REM1_VAL     8'h25
`define OFS_LOCAL_VAL    8'h26
`define OFS_REM2_VAL     8'h27
`define OFS_MAXDUTY1     8'h38
`define OFS_MAXDUTY2     8'h39
`define OFS_MAXDUTY3     8'h3A
`define OFS_CORE_LO      8'h46
`define OFS_CORE_HI      8'h47
`define OFS_MAIN_LO      8'h48
`define OFS_MAIN_HI      8'h49
`define OFS_REM1_LO      8'h4E
`define OFS_REM1_HI      8'h4F
`define OFS_LOCAL_LO     8'h50
`define OFS_LOCAL_HI     8'h51
`define OFS_REM2_LO      8'h52
`define OFS_REM2_HI      8'h53
`define OFS_FAN1_LO      8'h54
`define OFS_FAN1_HI      8'h55
`define OFS_REM1_OT      8'h6A
`define OFS_LOCAL_OT     8'h6B
`define OFS_REM2_OT      8'h6C
`define OFS_HYST_A       8'h6D
`define OFS_HYST_B       8'h6E
`define OFS_CONV_CFG     8'h73
`define OFS_FRAC         8'h77
`define OFS_BOOST_CFG    8'h78
`define OFS_OT_TIMER     8'h7A
`define OFS_FORMAT_CFG   8'h7C
`define OFS_DUTY_CFG     8'h7D

// Reset values.
`define RST_ZERO         8'h00
`define RST_FF           8'hFF
`define RST_TEMP_LO      8'h01
`define RST_TEMP_HI      8'h7F
`define RST_OT_LIM       8'hA4
`define RST_HYST_A       8'h44
`define RST_HYST_B       8'h40

// Field positions.
`define BIT_COMPAT       1
`define BIT_AVG_OFF      4
`define BIT_SINGLE       6
`define BIT_USE_MAXDUTY  3
`define BIT_BOOST        2

// Format codes.
`define CODE_FAULT_CMP   8'h80
`define CODE_FAULT_EXT   8'h00
`define CODE_MIN_CMP     8'hC1
`define CODE_MAX_CMP     8'h7F
`define EXT_OFFSET       8'h40
`define EXT_TOP          8'hBF
`define DUTY_FULL        8'hFF

// Conversion times in microseconds, clock in MHz.
`define CLK_MHZ          10
`define VOLT_FAST_US     700
`define REM_FAST_US      7000
`define LOCAL_FAST_US    1300
`define VOLT_AVG_US      11000
`define REM_AVG_US       39000
`define LOCAL_AVG_US     12000
`define AVG_SHIFT        4

`endif

// File: core/temp_result_pkg.sv
/*
  Types shared by the temperature result and limit logic.
  Assumes the register header is included where offsets are needed.
*/
package temp_result_pkg;

  // Converter channels; temperature codes match the select field.
  typedef enum logic [2:0] {
    CH_CORE  = 3'b000,
    CH_MAIN  = 3'b001,
    CH_REM1  = 3'b101,
    CH_LOCAL = 3'b110,
    CH_REM2  = 3'b111
  } chan_type;

  // Per-channel out-of-limit status levels.
  typedef struct packed {
    logic core;
    logic main;
    logic rem1;
    logic local_t;
    logic rem2;
    logic fan1;
  } status_type;

  // Forced duty values for the three PWM outputs.
  typedef struct packed {
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
  } duty_type;

endpackage

// File: tb/temp_result_limit_logic_sva.sv
/* Port checker for the temperature result and limit logic.
   Assumes every conversion lasts at least nine clocks. */
`timescale 1ns/1ps
module temp_result_limit_logic_sva
  import temp_result_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register port.
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Converter, tach and fan forcing.
  input wire chan_type    conv_channel,
  input wire logic [15:0] fan1_period,
  input wire logic        fan1_period_valid,
  input wire logic        auto_fan_mode,
  input wire status_type  status,
  input wire logic        force_active
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_frac_pad_zero: assert property (
    reg_rd && reg_addr == 8'h77 |=> reg_rdata[1:0] == 2'b00)
    else $error("fraction pad bits set");
  chk_rdata_stands: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_chan_legal: assert property (
    conv_channel inside {CH_CORE, CH_MAIN, CH_REM1, CH_LOCAL, CH_REM2})
    else $error("illegal channel code");
  chk_chan_holds: assert property (
    $changed(conv_channel) |=> $stable(conv_channel) [*8])
    else $error("conversion too short");
  chk_force_needs_auto: assert property (
    !auto_fan_mode |=> !force_active)
    else $error("forcing outside automatic mode");
  chk_force_rise_cause: assert property (
    $rose(force_active) |-> $past(auto_fan_mode))
    else $error("forcing began without automatic mode");
  chk_tach_zero_ok: assert property (
    fan1_period_valid && fan1_period == 16'h0000 |=> !status.fan1)
    else $error("zero period flagged slow");
  chk_tach_status_hold: assert property (
    !fan1_period_valid |=> $stable(status.fan1))
    else $error("fan status moved without a period");

  // Main scenarios reached.
  cover property ($rose(force_active));
  cover property ($fell(force_active));
  cover property ($rose(status.fan1));
endmodule

bind temp_result_limit_logic temp_result_limit_logic_sva chk (
  .clk_sys (clk_sys), .rst (rst), .reg_addr (reg_addr),
  .reg_rd (reg_rd), .reg_rdata (reg_rdata),
  .conv_channel (conv_channel), .fan1_period (fan1_period),
  .fan1_period_valid (fan1_period_valid),
  .auto_fan_mode (auto_fan_mode), .status (status),
  .force_active (force_active)
);

// File: tb/temp_host_model.sv
/* Host model driving the decoded register port.
   Assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/1ps
module temp_host_model (
  // Clock.
  input  wire logic       clk_sys,
  // Register access toward the device.
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write strobe; released lines show inverted values.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One read strobe; data is taken once its edge has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  task automatic read_ten(output logic [7:0] v [4]);
    rd(8'h77, v[0]);
    for (int i = 1; i < 4; i++) rd(8'h24 + 8'(i), v[i]);
  endtask

  task automatic set_compat();
    wr(8'h7C, 8'h02);
    for (int i = 0; i < 6; i++) wr(8'h4E + 8'(i), i[0] ? 8'h7F : 8'hC1);
  endtask
endmodule

// File: tb/temp_result_limit_logic_bench.sv
/* Self-checking bench for the temperature result and limit logic.
   Assumes the host model owns the register port. */
`timescale 1ns/1ps
module temp_result_limit_logic_bench import temp_result_pkg::*;;
  localparam int LEN = 32;  // Short conversion length.
  localparam logic [7:0] RO [20] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4E,
    8'h4F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h6A, 8'h6B,
    8'h6C, 8'h6D, 8'h6E, 8'h7A, 8'h7C, 8'h01};
  localparam logic [7:0] RV [20] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h01,
    8'h7F, 8'h01, 8'h7F, 8'h01, 8'h7F, 8'hFF, 8'hFF, 8'hA4, 8'hA4,
    8'hA4, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};
  localparam logic [9:0] CC [3] = '{10'h3FF, 10'h1A3, 10'h000};
  localparam logic [7:0] HI [4] = '{8'h70, 8'h6F, 8'hFF, 8'hFF};
  localparam logic [7:0] LO [4] = '{8'h6F, 8'h6F, 8'h70, 8'h6F};
  localparam logic ST [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic [2:0] SEL [3] = '{3'b101, 3'b111, 3'b110};
  logic        clk_sys;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [9:0]  adc_temp;
  logic [7:0]  adc_volt;
  logic [1:0]  diode_fault;
  chan_type    conv_channel;
  logic [15:0] fan1_period;
  logic        fan1_period_valid;
  logic        auto_fan_mode;
  status_type  status;
  duty_type    force_duty;
  logic        force_active;
  int          n_mismatch;
  int          total_checks;
  logic [31:0] seed;
  logic [7:0]  md [3];
  logic [7:0]  t [4];
  logic [9:0]  c;

  temp_result_limit_logic #(.VOLT_FAST (LEN), .REM_FAST (LEN),
    .LOCAL_FAST (LEN), .VOLT_AVG (LEN), .REM_AVG (LEN),
    .LOCAL_AVG (LEN)) dut (
    .clk_sys (clk_sys), .rst (rst), .reg_addr (reg_addr),
    .reg_wdata (reg_wdata), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_rdata (reg_rdata), .adc_temp (adc_temp), .adc_volt (adc_volt),
    .diode_fault (diode_fault), .conv_channel (conv_channel),
    .fan1_period (fan1_period), .fan1_period_valid (fan1_period_valid),
    .auto_fan_mode (auto_fan_mode), .status (status),
    .force_duty (force_duty), .force_active (force_active));

  temp_host_model host (.clk_sys (clk_sys), .reg_addr (reg_addr),
    .reg_wdata (reg_wdata), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_rdata (reg_rdata));

  // Clock of 100 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Next xorshift state.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Stored byte in the compatible format, clamped.
  function automatic logic [7:0] exp_compat(input logic [9:0] v);
    if (v[9:2] == 8'h00) return 8'hC1;
    if (v[9:2] > 8'hBF) return 8'h7F;
    return v[9:2] - 8'h40;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_out(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t port %h expected %h", $time, g, e);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    cmp_byte(d, e);
  endtask

  // Long enough for every channel to convert twice.
  task automatic settle();
    repeat (400) @(posedge clk_sys);
    #1;
  endtask

  task automatic drive_temp(input logic [9:0] v);
    @(posedge clk_sys);
    adc_temp <= v;
  endtask

  // Waits for the forcing flag; running out ends the run.
  task automatic wait_force(input logic e);
    int k;
    k = 0;
    while (force_active !== e && k < 600) begin
      @(posedge clk_sys);
      #1 k++;
    end
    cmp_out({23'h0, force_active}, {23'h0, e});
    if (k == 600) finish_test();
  endtask

  task automatic tach(input logic [15:0] p, input logic e);
    @(posedge clk_sys);
    fan1_period <= p;
    fan1_period_valid <= 1'b1;
    @(posedge clk_sys);
    fan1_period_valid <= 1'b0;
    fan1_period <= ~p;
    repeat (2) @(posedge clk_sys);
    #1 cmp_out({23'h0, status.fan1}, {23'h0, e});
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("BAD %0t run limit reached", $time);
    finish_test();
  end

  initial begin
    rst = 1'b1;
    adc_temp = 10'h190;
    adc_volt = 8'h80;
    diode_fault = 2'b00;
    fan1_period = 16'h0000;
    fan1_period_valid = 1'b0;
    auto_fan_mode = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    seed = 32'd22;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (RO[i]) rd_chk(RO[i], RV[i]);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      md[i] = seed[7:0];
      host.wr(8'h38 + 8'(i), md[i]);
      rd_chk(8'h38 + 8'(i), md[i]);
    end
    // Averaged, then fast conversions, each read at full resolution.
    for (int m = 0; m < 2; m++) begin
      seed = xs(seed);
      c = {8'h50 + {2'b00, seed[5:0]}, seed[9:8]};
      drive_temp(c);
      adc_volt <= seed[17:10];
      host.wr(8'h73, m ? 8'h10 : 8'h00);
      settle();
      host.read_ten(t);
      cmp_byte(t[0], {c[1:0], c[1:0], c[1:0], 2'b00});
      for (int k = 1; k < 4; k++) cmp_byte(t[k], c[9:2]);
    end
    // A fractional read holds the values until each is read.
    host.rd(8'h77, t[0]);
    drive_temp(c + 10'h040);
    settle();
    rd_chk(8'h25, c[9:2]);
    rd_chk(8'h27, c[9:2]);
    rd_chk(8'h26, c[9:2]);
    settle();
    rd_chk(8'h25, c[9:2] + 8'h10);
    drive_temp(c);
    settle();
    rd_chk(8'h27, c[9:2]);
    // Compatible format: clamping, limit floor and fault codes.
    host.set_compat();
    foreach (CC[i]) begin
      drive_temp(CC[i]);
      settle();
      rd_chk(8'h26, exp_compat(CC[i]));
    end
    host.wr(8'h50, 8'h80);
    settle();
    cmp_out({23'h0, status.local_t}, 24'h1);
    @(posedge clk_sys);
    diode_fault <= 2'b01;
    settle();
    rd_chk(8'h25, 8'h80);
    host.wr(8'h7C, 8'h00);
    settle();
    rd_chk(8'h25, 8'h00);
    @(posedge clk_sys);
    diode_fault <= 2'b00;
    // Window compare on the local channel at its boundaries.
    drive_temp({8'h70, 2'b00});
    foreach (HI[i]) begin
      host.wr(8'h51, HI[i]);
      host.wr(8'h50, LO[i]);
      settle();
      cmp_out(24'(status[5:1]),
        {19'h0, {2{~|adc_volt}}, 1'b1, ST[i], 1'b1});
    end
    host.wr(8'h73, 8'h40);
    foreach (SEL[i]) begin
      host.wr(8'h55, {SEL[i], 5'h1F});
      settle();
      cmp_out({21'h0, conv_channel}, {21'h0, SEL[i]});
    end
    seed = xs(seed);
    host.wr(8'h54, seed[7:0]);
    tach({8'hDF, seed[7:0]}, 1'b0);
    tach({8'hDF, seed[7:0]} + 16'h1, 1'b1);
    tach(16'h0, 1'b0);
    // Forcing trips above the limit, releases below limit minus 4, or at the limit with boost.
    host.wr(8'h6A, 8'hFF);
    host.wr(8'h6C, 8'hFF);
    host.wr(8'h6B, 8'h80);
    @(posedge clk_sys);
    auto_fan_mode <= 1'b1;
    drive_temp({8'h81, 2'b00});
    wait_force(1'b1);
    settle();
    cmp_out(force_duty, 24'hFFFFFF);
    host.wr(8'h7D, 8'h08);
    settle();
    cmp_out(force_duty, {md[2], md[1], md[0]});
    drive_temp({8'h7C, 2'b00});
    settle();
    cmp_out({23'h0, force_active}, 24'h1);
    drive_temp({8'h7B, 2'b00});
    wait_force(1'b0);
    host.wr(8'h78, 8'h04);
    drive_temp({8'h81, 2'b00});
    wait_force(1'b1);
    drive_temp({8'h80, 2'b00});
    wait_force(1'b0);
    @(posedge clk_sys);
    auto_fan_mode <= 1'b0;
    finish_test();
  end
endmodule
